// ### pkg/rlp_pkg.sv
package rlp_pkg;

  // Register port geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;

  // Register offsets
  localparam logic [7:0]  OFS_TLOOP     = 8'h06;
  localparam logic [7:0]  OFS_AFE       = 8'h07;
  localparam logic [7:0]  OFS_PHASE     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;
  localparam logic [7:0]  OFS_MASK      = 8'h11;

  // Reset values and writable bits
  localparam logic [15:0] RST_TLOOP     = 16'h0514;
  localparam logic [15:0] RST_AFE       = 16'h0005;
  localparam logic [15:0] RST_PHASE     = 16'h1400;
  localparam logic [15:0] WMASK_TLOOP   = 16'h07FF;
  localparam logic [15:0] WMASK_AFE     = 16'h000F;
  localparam logic [15:0] WMASK_PHASE   = 16'hFFFF;

  // Tracking-loop field positions
  localparam int          MULT_LSB      = 9;
  localparam int          KP_LSB        = 6;
  localparam int          HYS_LSB       = 4;
  localparam int          CLKSEL_BIT    = 3;
  localparam int          KI_LSB        = 0;

  // Front-end gain field positions
  localparam int          GCOS_LSB      = 2;
  localparam int          GSIN_LSB      = 0;

  // Phase and exciter field positions
  localparam int          UVCFG_LSB     = 14;
  localparam int          MAN_EN_BIT    = 13;
  localparam int          AUTO_EN_BIT   = 12;
  localparam int          MODE_LSB      = 10;
  localparam int          FOOT_LSB      = 6;
  localparam int          PDLY_LSB      = 0;
  localparam int          PDLY_SIGN_BIT = 5;

  // Status and mask bit positions
  localparam int          STAT_MODE_BIT = 0;
  localparam int          STAT_UV_BIT   = 1;

  // Decode constants
  localparam logic [6:0]  MULT_BASE     = 7'h08;
  localparam logic [9:0]  KP_BASE_10    = 10'h010;
  localparam logic [9:0]  KP_BASE_12    = 10'h004;
  localparam logic [2:0]  KP_MAX_CODE   = 3'h5;
  localparam logic [3:0]  KI_BASE_EXP   = 4'h8;
  localparam logic [1:0]  HYS_ONE_LSB   = 2'h1;
  localparam logic [1:0]  MODE_4VRMS    = 2'h1;
  localparam logic [1:0]  MODE_7VRMS    = 2'h2;
  localparam logic [4:0]  FOOT_TOP_DV   = 5'h14;
  localparam logic [3:0]  FOOT_LAST_LIN = 4'hC;
  localparam logic [3:0]  FOOT_LOW_CODE = 4'hF;
  localparam logic [4:0]  FOOT_LOW_DV   = 5'h05;
  localparam logic [4:0]  FOOT_GAP_DV   = 5'h08;

  // Timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          OR_DEGL_US    = 50;
  localparam int          AND_DEGL_US   = 1;
  localparam int          PHASE_STEP_NS = 400;
  localparam int          OR_DEGL_CYC   = (OR_DEGL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          AND_DEGL_CYC  = (AND_DEGL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PHASE_STEP_CYC = PHASE_STEP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] OR_LAST       = 12'(OR_DEGL_CYC - 1);
  localparam logic [11:0] AND_LAST      = 12'(AND_DEGL_CYC - 1);
  localparam logic [2:0]  PHASE_STEP    = 3'(PHASE_STEP_CYC);

endpackage

// ### pkg/rlp_uv_if.sv
`timescale 1ns/100ps
interface rlp_uv_if;
  logic [1:0] uv_raw;
  logic [1:0] combine_cfg;
  logic       uv_fault;

  modport ctrl (output uv_raw, output combine_cfg, input uv_fault);
  modport filt (input uv_raw, input combine_cfg, output uv_fault);
endinterface

// ### logic/rlp_uv_deglitch.sv
`timescale 1ns/100ps
module rlp_uv_deglitch (
  input wire logic clock,    // System clock
  input wire logic reset_n,  // Async reset
  rlp_uv_if.filt   uv        // Raw indicators in, fault flag out
);

  typedef struct packed {
    logic [1:0][11:0] in_cnt;
    logic [1:0]       in_flt;
    logic [11:0]      and_cnt;
    logic             and_flt;
    logic             fault;
  } rlp_dg_state_t;

  rlp_dg_state_t    st_ff;
  rlp_dg_state_t    nxt_st;
  logic [1:0][11:0] nxt_in_cnt;
  logic [1:0]       nxt_in_flt;
  logic             and_raw;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Per-input deglitch ahead of the OR
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_in
    assign nxt_in_cnt[gi] = (uv.uv_raw[gi] == st_ff.in_flt[gi]) ? 12'h000 :
                            st_ff.in_cnt[gi] + 12'h001;
    assign nxt_in_flt[gi] = (uv.uv_raw[gi] != st_ff.in_flt[gi] &&
                             st_ff.in_cnt[gi] == rlp_pkg::OR_LAST) ?
                            uv.uv_raw[gi] : st_ff.in_flt[gi];
  end

  assign and_raw = &uv.uv_raw;

  // AND output deglitch and flag combination
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.in_cnt = nxt_in_cnt;
    nxt_st.in_flt = nxt_in_flt;
    if (and_raw == st_ff.and_flt) begin
      nxt_st.and_cnt = 12'h000;
    end else begin
      nxt_st.and_cnt = st_ff.and_cnt + 12'h001;
      if (st_ff.and_cnt == rlp_pkg::AND_LAST) begin
        nxt_st.and_flt = and_raw;
      end
    end
    case (uv.combine_cfg)
      2'h2:    nxt_st.fault = st_ff.and_flt;                      // RULE6
      2'h3:    nxt_st.fault = (|st_ff.in_flt) | st_ff.and_flt;    // RULE6
      default: nxt_st.fault = |st_ff.in_flt;                      // RULE6
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign uv.uv_fault = st_ff.fault;

  property p_uv_or_quiet;
    !uv.combine_cfg[1] && st_ff.in_flt == 2'h0 |=> !st_ff.fault;
  endproperty
  a_uv_or_quiet: assert property (p_uv_or_quiet) else $error("uv flag set with quiet inputs"); // RULE6

endmodule

// ### logic/rlp_loop_phase_config.sv
// Behaviour
// RULE1: Multiplier field bits 10:9 selects loop gain multiplier 8, 16, 32, 64.
// RULE2: Constant field bits 8:6 gives 16..512 in 10-bit, 4..128 in 12-bit mode.
// RULE3: Hysteresis bits 5:4: 00 off, 01 one LSB; software avoids 1x codes.
// RULE4: Clock select bit 3 at 0 takes exciter clock from system clock.
// RULE5: Integration weight bits 2:0 give 2^8..2^13, 111 gives 2^15; reset 100.
// RULE6: Bits 15:14 pick OR, AND or both combinations of deglitched undervoltage inputs.
// RULE7: Manual phase enable bit 13 applies manual delay, otherwise no delay.
// RULE8: Manual phase delay takes precedence over automatic phase correction.
// RULE9: Bit 12 enables automatic phase control, set after reset.
// RULE10: Mode 00/11 disables exciter, raises fault and mode fault; 01 4 Vrms, 10 7 Vrms.
// RULE11: Footroom bits 9:6: 2.0 V down by 0.1 V to 0.8 V, 1111 is 0.5 V.
// RULE12: Tracking loop at 6h reset 0514h, front-end gain at 7h, phase at 8h.
// RULE13: Manual delay is low five bits times 0.4 us, bit five is the sign.
// RULE14: Registers are sixteen bits, reserved bits read zero and ignore writes.
`timescale 1ns/100ps
module rlp_loop_phase_config (
  input  wire logic        clock,                    // 10 MHz system clock
  input  wire logic        reset_n,                  // Async reset
  input  wire logic [7:0]  reg_addr,                 // Register address
  input  wire logic [15:0] reg_wdata,                // Write data
  input  wire logic        reg_wr,                   // Write strobe
  input  wire logic        reg_rd,                   // Read strobe
  output logic      [15:0] reg_rdata,                // Read data, cycle after strobe
  input  wire logic        resolution_12bit,         // High for 12-bit mode
  input  wire logic        exciter_undervoltage_one, // First undervoltage indicator
  input  wire logic        exciter_undervoltage_two, // Second undervoltage indicator
  output logic      [6:0]  loop_gain_multiplier,     // Multiplier 8..64
  output logic      [9:0]  loop_gain_constant,       // Gain constant 4..512
  output logic      [3:0]  integration_weight,       // Weight exponent 8..15
  output logic             angle_hysteresis,         // One LSB hysteresis active
  output logic             exciter_clock_source,     // High when from system clock
  output logic      [1:0]  sine_front_end_gain,      // Sine gain code
  output logic      [1:0]  cosine_front_end_gain,    // Cosine gain code
  output logic             exciter_enable,           // Exciter running
  output logic             exciter_amplitude_select, // High for 7 Vrms
  output logic             fault_out,                // Fault pin level
  output logic      [4:0]  exciter_footroom,         // Footroom in 0.1 V units
  output logic             manual_phase_enable,      // Manual delay applied
  output logic      [7:0]  manual_phase_delay,       // Signed delay in clocks
  output logic             auto_phase_enable,        // Automatic correction active
  output logic             exciter_undervoltage_flag,// Combined undervoltage flag
  output logic             irq                       // Level interrupt
);

  typedef struct packed {
    logic [15:0] tloop;
    logic [15:0] afe;
    logic [15:0] phase;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] rdata;
    logic [6:0]  mult;
    logic [9:0]  kp;
    logic [3:0]  ki_exp;
    logic        hys_on;
    logic        clk_sys;
    logic [1:0]  gsin;
    logic [1:0]  gcos;
    logic        exc_en;
    logic        exc_7v;
    logic        fault_out;
    logic [4:0]  foot;
    logic        man_act;
    logic [7:0]  man_dly;
    logic        auto_act;
    logic        irq;
  } rlp_cfg_state_t;

  rlp_cfg_state_t st_ff;
  rlp_cfg_state_t nxt_st;
  logic           tloop_wr;
  logic           phase_wr;
  logic [1:0]     mode_code;
  logic           mode_bad;
  logic [2:0]     kp_code;
  logic [3:0]     foot_code;
  logic [6:0]     dly_mag;
  logic [1:0]     events;

  rlp_uv_if       uv_bus ();

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Undervoltage flag formation
  assign uv_bus.uv_raw      = {exciter_undervoltage_two, exciter_undervoltage_one};
  assign uv_bus.combine_cfg = st_ff.phase[rlp_pkg::UVCFG_LSB +: 2];                // RULE6

  rlp_uv_deglitch u_uv_deglitch (
    .clock   (clock),
    .reset_n (reset_n),
    .uv      (uv_bus)
  );

  // Write decodes, events and field views of the stored registers
  assign tloop_wr  = reg_wr && reg_addr == rlp_pkg::OFS_TLOOP;
  assign phase_wr  = reg_wr && reg_addr == rlp_pkg::OFS_PHASE;
  assign mode_code = st_ff.phase[rlp_pkg::MODE_LSB +: 2];
  assign mode_bad  = mode_code != rlp_pkg::MODE_4VRMS && mode_code != rlp_pkg::MODE_7VRMS;
  assign kp_code   = st_ff.tloop[rlp_pkg::KP_LSB +: 3];
  assign foot_code = st_ff.phase[rlp_pkg::FOOT_LSB +: 4];
  assign dly_mag   = 7'(st_ff.phase[rlp_pkg::PDLY_LSB +: 5] * rlp_pkg::PHASE_STEP); // RULE13
  assign events    = {uv_bus.uv_fault, mode_bad};

  // Register writes, reads, status and decoders
  always_comb begin
    nxt_st = st_ff;
    // Writes, reserved bits dropped
    if (tloop_wr) begin
      nxt_st.tloop = reg_wdata & rlp_pkg::WMASK_TLOOP;                              // RULE14
    end
    if (reg_wr && reg_addr == rlp_pkg::OFS_AFE) begin
      nxt_st.afe = reg_wdata & rlp_pkg::WMASK_AFE;                                  // RULE14
    end
    if (phase_wr) begin
      nxt_st.phase = reg_wdata & rlp_pkg::WMASK_PHASE;
    end
    if (reg_wr && reg_addr == rlp_pkg::OFS_MASK) begin
      nxt_st.mask = reg_wdata[1:0];
    end
    // Sticky status, set beats write-one clear
    nxt_st.status = st_ff.status;
    if (reg_wr && reg_addr == rlp_pkg::OFS_STATUS) begin
      nxt_st.status = st_ff.status & ~reg_wdata[1:0];
    end
    nxt_st.status = nxt_st.status | events;                                         // RULE10
    nxt_st.irq    = |(st_ff.status & st_ff.mask);
    // Read data only in the cycle after the strobe
    nxt_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        rlp_pkg::OFS_TLOOP:  nxt_st.rdata = st_ff.tloop;                            // RULE12
        rlp_pkg::OFS_AFE:    nxt_st.rdata = st_ff.afe;                              // RULE12
        rlp_pkg::OFS_PHASE:  nxt_st.rdata = st_ff.phase;                            // RULE12
        rlp_pkg::OFS_STATUS: nxt_st.rdata = {14'h0000, st_ff.status};
        rlp_pkg::OFS_MASK:   nxt_st.rdata = {14'h0000, st_ff.mask};
        default:             nxt_st.rdata = 16'h0000;
      endcase
    end
    // Tracking loop decode
    nxt_st.mult = 7'(rlp_pkg::MULT_BASE << st_ff.tloop[rlp_pkg::MULT_LSB +: 2]);   // RULE1
    nxt_st.kp   = 10'((resolution_12bit ? rlp_pkg::KP_BASE_12 : rlp_pkg::KP_BASE_10)
                  << ((kp_code > rlp_pkg::KP_MAX_CODE) ? rlp_pkg::KP_MAX_CODE : kp_code)); // RULE2
    nxt_st.hys_on  = st_ff.tloop[rlp_pkg::HYS_LSB +: 2] == rlp_pkg::HYS_ONE_LSB;     // RULE3
    nxt_st.clk_sys = !st_ff.tloop[rlp_pkg::CLKSEL_BIT];                             // RULE4
    nxt_st.ki_exp  = rlp_pkg::KI_BASE_EXP + {1'h0, st_ff.tloop[rlp_pkg::KI_LSB +: 3]}; // RULE5
    // Front-end gains
    nxt_st.gsin = st_ff.afe[rlp_pkg::GSIN_LSB +: 2];
    nxt_st.gcos = st_ff.afe[rlp_pkg::GCOS_LSB +: 2];
    // Exciter mode
    nxt_st.exc_en    = !mode_bad;                                                   // RULE10
    nxt_st.exc_7v    = mode_code == rlp_pkg::MODE_7VRMS;                            // RULE10
    nxt_st.fault_out = mode_bad;                                                    // RULE10
    // Footroom in tenths of a volt
    if (foot_code <= rlp_pkg::FOOT_LAST_LIN) begin
      nxt_st.foot = rlp_pkg::FOOT_TOP_DV - {1'h0, foot_code};                      // RULE11
    end else if (foot_code == rlp_pkg::FOOT_LOW_CODE) begin
      nxt_st.foot = rlp_pkg::FOOT_LOW_DV;                                           // RULE11
    end else begin
      nxt_st.foot = rlp_pkg::FOOT_GAP_DV;
    end
    // Phase correction selection
    nxt_st.man_act = st_ff.phase[rlp_pkg::MAN_EN_BIT];                              // RULE7
    if (!st_ff.phase[rlp_pkg::MAN_EN_BIT]) begin
      nxt_st.man_dly = 8'h00;                                                       // RULE7
    end else if (st_ff.phase[rlp_pkg::PDLY_SIGN_BIT]) begin
      nxt_st.man_dly = 8'h00 - {1'h0, dly_mag};                                     // RULE13
    end else begin
      nxt_st.man_dly = {1'h0, dly_mag};                                             // RULE13
    end
    nxt_st.auto_act = st_ff.phase[rlp_pkg::AUTO_EN_BIT] &&
                      !st_ff.phase[rlp_pkg::MAN_EN_BIT];                            // RULE8 RULE9
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.tloop    <= rlp_pkg::RST_TLOOP;                                         // RULE12
      st_ff.afe      <= rlp_pkg::RST_AFE;
      st_ff.phase    <= rlp_pkg::RST_PHASE;                                         // RULE9
      st_ff.mult     <= 7'h20;
      st_ff.kp       <= 10'h100;
      st_ff.ki_exp   <= 4'hC;                                                       // RULE5
      st_ff.hys_on   <= 1'h1;
      st_ff.clk_sys  <= 1'h1;
      st_ff.gsin     <= 2'h1;
      st_ff.gcos     <= 2'h1;
      st_ff.exc_en   <= 1'h1;
      st_ff.foot     <= 5'h14;
      st_ff.auto_act <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register, undervoltage flag from u_uv_deglitch
  assign reg_rdata                 = st_ff.rdata;
  assign loop_gain_multiplier      = st_ff.mult;
  assign loop_gain_constant        = st_ff.kp;
  assign integration_weight        = st_ff.ki_exp;
  assign angle_hysteresis          = st_ff.hys_on;
  assign exciter_clock_source      = st_ff.clk_sys;
  assign sine_front_end_gain       = st_ff.gsin;
  assign cosine_front_end_gain     = st_ff.gcos;
  assign exciter_enable            = st_ff.exc_en;
  assign exciter_amplitude_select  = st_ff.exc_7v;
  assign fault_out                 = st_ff.fault_out;
  assign exciter_footroom          = st_ff.foot;
  assign manual_phase_enable       = st_ff.man_act;
  assign manual_phase_delay        = st_ff.man_dly;
  assign auto_phase_enable         = st_ff.auto_act;
  assign exciter_undervoltage_flag = uv_bus.uv_fault;
  assign irq                       = st_ff.irq;

  // Checks on the decoders and the register port
  property p_mult;
    tloop_wr ##1 !tloop_wr |=> st_ff.mult == 7'(rlp_pkg::MULT_BASE << $past(reg_wdata[10:9], 2));
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier mismatch"); // RULE1

  property p_kp;
    $past(kp_code) == 3'h5 |-> st_ff.kp == ($past(resolution_12bit) ? 10'h080 : 10'h200);
  endproperty
  a_kp: assert property (p_kp) else $error("gain constant mismatch"); // RULE2

  property p_hys;
    st_ff.hys_on |-> $past(st_ff.tloop[5:4]) == 2'h1;
  endproperty
  a_hys: assert property (p_hys) else $error("hysteresis on for wrong code"); // RULE3

  property p_clk;
    $past(st_ff.tloop[3]) == 1'h0 |-> st_ff.clk_sys;
  endproperty
  a_clk: assert property (p_clk) else $error("exciter clock not from system"); // RULE4

  property p_ki;
    $past(st_ff.tloop[2:0]) == 3'h7 |-> st_ff.ki_exp == 4'hF;
  endproperty
  a_ki: assert property (p_ki) else $error("integration weight mismatch"); // RULE5

  property p_man_off;
    !st_ff.phase[13] |=> st_ff.man_dly == 8'h00 && !st_ff.man_act;
  endproperty
  a_man_off: assert property (p_man_off) else $error("manual delay while disabled"); // RULE7

  property p_prec;
    st_ff.man_act |-> !st_ff.auto_act;
  endproperty
  a_prec: assert property (p_prec) else $error("auto phase beside manual phase"); // RULE8

  property p_auto;
    $past(st_ff.phase[12]) && !$past(st_ff.phase[13]) |-> st_ff.auto_act;
  endproperty
  a_auto: assert property (p_auto) else $error("auto phase not active"); // RULE9

  property p_mode;
    phase_wr && reg_wdata[11:10] == 2'h0 ##1 !phase_wr |=> st_ff.fault_out && st_ff.status[0];
  endproperty
  a_mode: assert property (p_mode) else $error("exciter off without fault"); // RULE10

  property p_foot;
    $past(foot_code) == 4'hF |-> st_ff.foot == 5'h05;
  endproperty
  a_foot: assert property (p_foot) else $error("footroom mismatch"); // RULE11

  property p_rd;
    reg_rd && reg_addr == rlp_pkg::OFS_TLOOP |=> reg_rdata == $past(st_ff.tloop);
  endproperty
  a_rd: assert property (p_rd) else $error("tracking loop read mismatch"); // RULE12

  property p_dly;
    $past(st_ff.phase[13]) && $past(st_ff.phase[5:0]) == 6'h21 |-> st_ff.man_dly == 8'hFC;
  endproperty
  a_dly: assert property (p_dly) else $error("negative delay mismatch"); // RULE13

  property p_rsv;
    reg_rd && reg_addr == rlp_pkg::OFS_AFE |=> reg_rdata[15:4] == 12'h000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero"); // RULE14

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle"); // RULE12

  property p_rsv_wr;
    tloop_wr |=> st_ff.tloop[15:11] == 5'h00;
  endproperty
  a_rsv_wr: assert property (p_rsv_wr) else $error("reserved bits stored"); // RULE14

  property p_mode_set;
    mode_bad |=> st_ff.status[rlp_pkg::STAT_MODE_BIT];
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("mode fault not latched"); // RULE10

  property p_uv_set;
    uv_bus.uv_fault |=> st_ff.status[rlp_pkg::STAT_UV_BIT];
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("undervoltage not latched"); // RULE6

  property p_irq;
    st_ff.irq == $past(|(st_ff.status & st_ff.mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch"); // RULE10

  property p_exc_7v;
    $past(mode_code) == 2'h2 |-> st_ff.exc_en && st_ff.exc_7v && !st_ff.fault_out;
  endproperty
  a_exc_7v: assert property (p_exc_7v) else $error("7 Vrms mode not applied"); // RULE10

endmodule

// ### sim/rlp_loop_phase_config_test.sv
`timescale 1ns/100ps
module rlp_loop_phase_config_test;
  logic        clock;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        resolution_12bit;
  logic        exciter_undervoltage_one;
  logic        exciter_undervoltage_two;
  logic [6:0]  loop_gain_multiplier;
  logic [9:0]  loop_gain_constant;
  logic [3:0]  integration_weight;
  logic        angle_hysteresis;
  logic        exciter_clock_source;
  logic [1:0]  sine_front_end_gain;
  logic [1:0]  cosine_front_end_gain;
  logic        exciter_enable;
  logic        exciter_amplitude_select;
  logic        fault_out;
  logic [4:0]  exciter_footroom;
  logic        manual_phase_enable;
  logic [7:0]  manual_phase_delay;
  logic        auto_phase_enable;
  logic        exciter_undervoltage_flag;
  logic        irq;
  int          mismatches;
  int          checked;

  rlp_loop_phase_config DUT (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .resolution_12bit, .exciter_undervoltage_one, .exciter_undervoltage_two,
    .loop_gain_multiplier, .loop_gain_constant, .integration_weight, .angle_hysteresis,
    .exciter_clock_source, .sine_front_end_gain, .cosine_front_end_gain, .exciter_enable,
    .exciter_amplitude_select, .fault_out, .exciter_footroom, .manual_phase_enable,
    .manual_phase_delay, .auto_phase_enable, .exciter_undervoltage_flag, .irq);

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Closing report
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe, data sampled in the following cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check(reg_rdata, exp);
  endtask

  // Let decoded outputs follow a write
  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  // Bounded wait for the undervoltage flag to reach a level
  task automatic wait_flag(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (exciter_undervoltage_flag !== lvl && n < hi) begin
      @(negedge clock);
      n++;
    end
    check({15'h0, n >= lo && exciter_undervoltage_flag === lvl}, 16'h1);
    if (exciter_undervoltage_flag !== lvl) print_verdict();
  endtask

  // Reset values of registers and decoded outputs
  task automatic test_reset();
    settle();
    rd(rlp_pkg::OFS_TLOOP, 16'h0514);
    rd(rlp_pkg::OFS_AFE, 16'h0005);
    rd(rlp_pkg::OFS_PHASE, 16'h1400);
    check(16'(loop_gain_multiplier), 16'h0020);
    check(16'(loop_gain_constant), 16'h0100);
    check(16'(integration_weight), 16'h000C);
    check({14'h0, auto_phase_enable, exciter_enable}, 16'h0003);
    check({14'h0, fault_out, irq}, 16'h0000);
    $display("reset test done");
  endtask

  // Every tracking-loop code but hysteresis 1x in both resolutions, reserved bits written high
  task automatic test_tloop();
    int k;
    logic [2:0] c;
    logic [15:0] d;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) begin
        c = 3'(i);
        k = (i > 5) ? 5 : i;
        d = {5'h1F, c[1:0], c, 1'b0, c[0], c[0], c};
        @(posedge clock);
        resolution_12bit <= r[0];
        wr(rlp_pkg::OFS_TLOOP, d);
        settle();
        check(16'(loop_gain_multiplier), 16'(8 << c[1:0]));
        check(16'(loop_gain_constant), 16'((r == 1 ? 4 : 16) << k));
        check(16'(integration_weight), 16'(i == 7 ? 15 : 8 + i));
        check(16'(angle_hysteresis), 16'(c[0]));
        check(16'(exciter_clock_source), 16'(!c[0]));
        rd(rlp_pkg::OFS_TLOOP, d & 16'h07FF);
      end
    end
    $display("tracking loop test done");
  endtask

  // Exciter mode and footroom across all codes, phase enables and sixteen delay codes
  task automatic test_phase();
    logic [3:0] c;
    logic [5:0] dl;
    logic [15:0] d;
    int m;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      dl = 6'(i * 3);
      m = int'(dl[4:0]) * 4;
      d = {2'h0, c[0], c[1], c[1:0], c, dl};
      wr(rlp_pkg::OFS_PHASE, d);
      settle();
      check(16'(fault_out), 16'(c[1:0] == 2'h0 || c[1:0] == 2'h3));
      check({14'h0, exciter_enable, exciter_amplitude_select}, {14'h0, ^c[1:0], c[1:0] == 2'h2});
      check(16'(exciter_footroom), 16'(c <= 12 ? 20 - i : (c == 15 ? 5 : 8)));
      check(16'(manual_phase_enable), 16'(c[0]));
      check(16'(auto_phase_enable), 16'(c[1] & ~c[0]));
      check(16'(manual_phase_delay), 16'(c[0] ? 8'(dl[5] ? -m : m) : 8'h00));
      rd(rlp_pkg::OFS_PHASE, d);
    end
    $display("phase test done");
  endtask

  // Front-end gains, reserved bits and an unmapped address
  task automatic test_afe();
    wr(rlp_pkg::OFS_AFE, 16'hFFFF);
    rd(rlp_pkg::OFS_AFE, 16'h000F);
    wr(rlp_pkg::OFS_AFE, 16'h0006);
    wr(8'h20, 16'hFFFF);
    settle();
    check({12'h0, cosine_front_end_gain, sine_front_end_gain}, 16'h0006);
    rd(8'h20, 16'h0000);
    rd(rlp_pkg::OFS_AFE, 16'h0006);
    $display("front end test done");
  endtask

  // Mode fault interrupt: raise, hold while bad, mask, clear
  task automatic test_irq();
    wr(rlp_pkg::OFS_MASK, 16'h0001);
    wr(rlp_pkg::OFS_PHASE, 16'h0000);
    wr(rlp_pkg::OFS_STATUS, 16'h0003);
    settle();
    check({14'h0, fault_out, irq}, 16'h0003);
    rd(rlp_pkg::OFS_STATUS, 16'h0001);
    wr(rlp_pkg::OFS_PHASE, 16'h1400);
    wr(rlp_pkg::OFS_STATUS, 16'h0001);
    settle();
    check(16'(irq), 16'h0000);
    rd(rlp_pkg::OFS_STATUS, 16'h0000);
    wr(rlp_pkg::OFS_MASK, 16'h0000);
    wr(rlp_pkg::OFS_PHASE, 16'h0C00);
    settle();
    check(16'(irq), 16'h0000);
    rd(rlp_pkg::OFS_STATUS, 16'h0001);
    wr(rlp_pkg::OFS_PHASE, 16'h1400);
    wr(rlp_pkg::OFS_STATUS, 16'h0001);
    $display("interrupt test done");
  endtask

  // Undervoltage combining in OR and AND configurations
  task automatic test_uv();
    wr(rlp_pkg::OFS_MASK, 16'h0002);
    @(posedge clock);
    exciter_undervoltage_one <= 1'b1;
    wait_flag(1'b1, rlp_pkg::OR_DEGL_CYC - 2, rlp_pkg::OR_DEGL_CYC + 4);
    settle();
    check(16'(irq), 16'h0001);
    @(posedge clock);
    exciter_undervoltage_one <= 1'b0;
    wait_flag(1'b0, rlp_pkg::OR_DEGL_CYC - 2, rlp_pkg::OR_DEGL_CYC + 4);
    wr(rlp_pkg::OFS_PHASE, 16'h9400);
    exciter_undervoltage_one <= 1'b1;
    repeat (3 * rlp_pkg::AND_DEGL_CYC) @(negedge clock);
    check(16'(exciter_undervoltage_flag), 16'h0000);
    @(posedge clock);
    exciter_undervoltage_two <= 1'b1;
    wait_flag(1'b1, rlp_pkg::AND_DEGL_CYC - 2, rlp_pkg::AND_DEGL_CYC + 4);
    $display("undervoltage test done");
  endtask

  // Main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    resolution_12bit = 1'b0;
    exciter_undervoltage_one = 1'b0;
    exciter_undervoltage_two = 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    test_reset();
    test_tloop();
    test_phase();
    test_afe();
    test_irq();
    test_uv();
    print_verdict();
  end
endmodule
